// ===== shared/pin_redirect_consts.vh
// register map, field positions and pin indices for the pin redirect block
`ifndef PIN_REDIRECT_CONSTS_VH
`define PIN_REDIRECT_CONSTS_VH
// printed register indices; byte address is four times the index
`define IDX_PIN_CLOCK 8'h00a1
`define IDX_RELOCATION 8'h00a2
`define IDX_IRQ_SOURCE 8'h00a3
`define ADDR_PIN_CLOCK 12'h0284
`define ADDR_RELOCATION 12'h0288
`define ADDR_IRQ_SOURCE 12'h028c
`define RST_PIN_CLOCK 8'h0000
`define RST_RELOCATION 8'h0000
`define RST_IRQ_SOURCE 8'h0000
// aux_pin_clock_control fields
`define F_P60_FUNC_HI 7
`define F_P60_FUNC_LO 6
`define F_P60_FAST 5
`define F_P4_SEL_HI 3
`define F_P4_SEL_LO 2
// aux_port_relocation fields
`define F_KBD_HI 7
`define F_KBD_LO 6
`define F_SPI_REL 5
`define F_UART2_REL 4
`define F_T2_REL 3
`define F_PCA_REL 2
// aux_interrupt_source_select fields
`define F_IRQ3_HI 7
`define F_IRQ3_LO 6
`define F_IRQ2_HI 5
`define F_IRQ2_LO 4
// system clock source codes
`define CLK_INTERNAL_RC 2'h0
`define CLK_CRYSTAL 2'h1
`define CLK_EXTERNAL 2'h2
// axi responses
`define RESP_OKAY 2'h0
`define RESP_SLVERR 2'h2
// flat pin index: port*8+bit
`define PIN(p, b) ((p) * 8 + (b))
`endif

// ===== hw/alternate_function_pin_redirect.v
// pin multiplexer steering peripheral functions to port pins, with axi4-lite registers
// Overview of operation
// R1: all redirect bits clear puts every alternate function on its default port 0-3 pin; external irq 2/3 own pins stay on p4.3/p4.2 here
// R2: software sets at most one relocation control bit at a time
// R3: port 6 bit 0 function field acts only with an internal rc system clock
// R4: crystal mode frees p6.0/p6.1 for crystal; external clock mode makes p6.0 input
// R5: function field 00 gpio, 01 master clock, 10 divided by 2, 11 divided by 4
// R6: software should set p6.0 push-pull when a clock is driven out
// R7: fast drive bit selects default or fast drive for p6.0
// R8: port 4 pair field maps gpio, uart0, external irq 2/3 or timer 3
// R9: keypad field picks port 0, 2, 5 or 6 as the eight keypad inputs
// R10: spi relocate bit moves spi pins from p1.4-7 to p5.4-7
// R11: second uart relocate bit moves rx/tx from p1.2/3 to p5.2/3
// R12: timer 2 relocate bit moves count/clock-out and trigger from p1.0/1 to p5.0/1
// R13: pca relocate bit moves clock input and six channels from p2.1-7 to p6.1-7
// R14: external irq 3 source is own pin, second uart rx, sda or spi select
// R15: external irq 2 source is own pin, first uart rx, sda or spi select
// R16: vacated pins fall back to gpio; target pins stop acting as gpio; keypad pins and p4.4/p4.5 as irq pins keep gpio drive here
`include "pin_redirect_consts.vh"
module alternate_function_pin_redirect #(
  parameter NPIN = 56
) (
  // clock and reset
  input wire sys_clk,
  input wire rstn,
  // axi4-lite slave
  input wire [11:0] s_axi_awaddr,
  input wire s_axi_awvalid,
  output reg s_axi_awready,
  input wire [31:0] s_axi_wdata,
  input wire [3:0] s_axi_wstrb,
  input wire s_axi_wvalid,
  output reg s_axi_wready,
  output reg [1:0] s_axi_bresp,
  output reg s_axi_bvalid,
  input wire s_axi_bready,
  input wire [11:0] s_axi_araddr,
  input wire s_axi_arvalid,
  output reg s_axi_arready,
  output reg [31:0] s_axi_rdata,
  output reg [1:0] s_axi_rresp,
  output reg s_axi_rvalid,
  input wire s_axi_rready,
  // pads, ports 0..6 flattened as port*8+bit
  input wire [NPIN-1:0] pin_in,
  output reg [NPIN-1:0] pin_out,
  output reg [NPIN-1:0] pin_oe,
  output reg p60_fast_drive,
  // gpio port latches
  input wire [NPIN-1:0] gpio_out,
  input wire [NPIN-1:0] gpio_oe,
  output reg [NPIN-1:0] gpio_in,
  // clock system
  input wire [1:0] clk_source,
  // spi: select, mosi, miso, clock
  input wire [3:0] spi_out,
  input wire [3:0] spi_oe,
  output reg [3:0] spi_in,
  // first uart
  input wire uart_first_tx,
  output reg uart_first_rx,
  // second uart
  input wire uart_second_tx,
  output reg uart_second_rx,
  // timer 2
  input wire timer_two_clock_out,
  input wire timer_two_clock_oe,
  output reg timer_two_count_in,
  output reg timer_two_ext_trigger,
  // timer 3
  input wire timer_three_clock_out,
  input wire timer_three_clock_oe,
  output reg timer_three_count_in,
  output reg timer_three_ext_trigger,
  // counter array
  input wire [5:0] pca_channel_out,
  input wire [5:0] pca_channel_oe,
  output reg [5:0] pca_channel_pin,
  output reg pca_ext_clock_in,
  // keypad and external interrupts
  output reg [7:0] keypad_irq_inputs,
  output reg ext_irq_two_in,
  output reg ext_irq_three_in
);

  reg [7:0] pin_clock_reg;
  reg [7:0] relocation_reg;
  reg [7:0] irq_source_reg;
  reg [NPIN-1:0] pin_meta_reg;
  reg [NPIN-1:0] pin_sync_reg;
  reg [2:0] clk_div_reg;
  reg aw_held_reg;
  reg w_held_reg;
  reg [11:0] aw_addr_reg;
  reg [7:0] w_data_reg;
  reg w_strb_reg;

  // combinational pin routing
  reg [NPIN-1:0] po_next;
  reg [NPIN-1:0] pe_next;
  reg [3:0] spi_in_next;
  reg uart1_rx_next;
  reg uart2_rx_next;
  reg t2_in_next;
  reg t2_ex_next;
  reg t3_in_next;
  reg t3_ex_next;
  reg [5:0] cex_next;
  reg eci_next;
  reg [7:0] kbd_next;
  reg irq2_next;
  reg irq3_next;
  reg drv_clk;
  integer spi_b;
  integer u2_b;
  integer t2_b;
  integer pca_b;
  integer kbd_b;
  integer u1_rx;
  integer u1_tx;
  integer t3_ex;
  integer t3_ck;
  integer i2_own;
  integer i3_own;
  integer i;

  wire [1:0] p60_func = pin_clock_reg[`F_P60_FUNC_HI:`F_P60_FUNC_LO];
  wire [1:0] p4_sel = pin_clock_reg[`F_P4_SEL_HI:`F_P4_SEL_LO];
  wire [1:0] kbd_sel = relocation_reg[`F_KBD_HI:`F_KBD_LO];
  wire [1:0] irq3_sel = irq_source_reg[`F_IRQ3_HI:`F_IRQ3_LO];
  wire [1:0] irq2_sel = irq_source_reg[`F_IRQ2_HI:`F_IRQ2_LO];

  always @* begin
    // every pin starts as gpio; functions then claim their active pin
    po_next = gpio_out; // R16
    pe_next = gpio_oe; // R16
    // overlapping relocations are not arbitrated: the later claim wins
    spi_b = relocation_reg[`F_SPI_REL] ? `PIN(5, 4) : `PIN(1, 4); // R10
    u2_b = relocation_reg[`F_UART2_REL] ? `PIN(5, 2) : `PIN(1, 2); // R11
    t2_b = relocation_reg[`F_T2_REL] ? `PIN(5, 0) : `PIN(1, 0); // R12
    pca_b = relocation_reg[`F_PCA_REL] ? `PIN(6, 1) : `PIN(2, 1); // R13
    case (kbd_sel) // R9
      2'h0: kbd_b = `PIN(0, 0);
      2'h1: kbd_b = `PIN(2, 0);
      2'h2: kbd_b = `PIN(5, 0);
      default: kbd_b = `PIN(6, 0);
    endcase
    // port 0..3 defaults, port 4 pair overrides
    u1_rx = `PIN(3, 0); // R1
    u1_tx = `PIN(3, 1); // R1
    t3_ex = `PIN(0, 0); // R1
    t3_ck = `PIN(0, 1); // R1
    i2_own = `PIN(4, 3);
    i3_own = `PIN(4, 2);
    case (p4_sel) // R8
      2'h1: begin
        u1_rx = `PIN(4, 4);
        u1_tx = `PIN(4, 5);
      end
      2'h2: begin
        i2_own = `PIN(4, 4);
        i3_own = `PIN(4, 5);
      end
      2'h3: begin
        t3_ex = `PIN(4, 4);
        t3_ck = `PIN(4, 5);
      end
      default: begin
        u1_rx = `PIN(3, 0);
      end
    endcase
    for (i = 0; i < 4; i = i + 1) begin
      po_next[spi_b+i] = spi_out[i]; // R10
      pe_next[spi_b+i] = spi_oe[i]; // R10
      spi_in_next[i] = pin_sync_reg[spi_b+i]; // R10
    end
    uart2_rx_next = pin_sync_reg[u2_b]; // R11
    pe_next[u2_b] = 1'b0; // R11
    po_next[u2_b+1] = uart_second_tx; // R11
    pe_next[u2_b+1] = 1'b1; // R11
    po_next[t2_b] = timer_two_clock_out; // R12
    pe_next[t2_b] = timer_two_clock_oe; // R12
    t2_in_next = pin_sync_reg[t2_b]; // R12
    t2_ex_next = pin_sync_reg[t2_b+1]; // R12
    pe_next[t2_b+1] = 1'b0; // R12
    eci_next = pin_sync_reg[pca_b]; // R13
    pe_next[pca_b] = 1'b0; // R13
    for (i = 0; i < 6; i = i + 1) begin
      po_next[pca_b+1+i] = pca_channel_out[i]; // R13
      pe_next[pca_b+1+i] = pca_channel_oe[i]; // R13
      cex_next[i] = pin_sync_reg[pca_b+1+i]; // R13
    end
    // uart0 and timer 3 always own their pins, default or port 4
    uart1_rx_next = pin_sync_reg[u1_rx]; // R8
    pe_next[u1_rx] = 1'b0; // R8
    po_next[u1_tx] = uart_first_tx; // R8
    pe_next[u1_tx] = 1'b1; // R8
    t3_ex_next = pin_sync_reg[t3_ex]; // R8
    pe_next[t3_ex] = 1'b0; // R8
    po_next[t3_ck] = timer_three_clock_out; // R8
    pe_next[t3_ck] = timer_three_clock_oe; // R8
    t3_in_next = pin_sync_reg[t3_ck]; // R8
    // keypad only listens, so it leaves the pins' drive alone
    kbd_next = pin_sync_reg[kbd_b +: 8]; // R9
    case (irq2_sel) // R15
      2'h0: irq2_next = pin_sync_reg[i2_own];
      2'h1: irq2_next = pin_sync_reg[u1_rx];
      2'h2: irq2_next = pin_sync_reg[`PIN(4, 1)];
      default: irq2_next = pin_sync_reg[spi_b];
    endcase
    case (irq3_sel) // R14
      2'h0: irq3_next = pin_sync_reg[i3_own];
      2'h1: irq3_next = pin_sync_reg[u2_b];
      2'h2: irq3_next = pin_sync_reg[`PIN(4, 1)];
      default: irq3_next = pin_sync_reg[spi_b];
    endcase
    // master clock on the pin is sys_clk/2, since it is divider bit 0, which toggles every cycle
    case (p60_func) // R5
      2'h1: drv_clk = clk_div_reg[0];
      2'h2: drv_clk = clk_div_reg[1];
      2'h3: drv_clk = clk_div_reg[2];
      default: drv_clk = 1'b0;
    endcase
    case (clk_source)
      `CLK_INTERNAL_RC: begin
        if (p60_func != 2'h0) begin // R3
          po_next[`PIN(6, 0)] = drv_clk; // R5
          pe_next[`PIN(6, 0)] = 1'b1; // R5
        end
      end
      `CLK_CRYSTAL: begin
        po_next[`PIN(6, 0)] = 1'b0; // R4
        pe_next[`PIN(6, 0)] = 1'b0; // R4
        po_next[`PIN(6, 1)] = 1'b0; // R4
        pe_next[`PIN(6, 1)] = 1'b0; // R4
      end
      default: begin
        po_next[`PIN(6, 0)] = 1'b0; // R4
        pe_next[`PIN(6, 0)] = 1'b0; // R4
      end
    endcase
  end

  // register file and axi4-lite slave
  wire wr_fire = aw_held_reg && w_held_reg && !s_axi_bvalid;
  reg wr_hit;
  reg rd_hit;
  reg [7:0] rd_byte;

  always @* begin
    wr_hit = (aw_addr_reg == `ADDR_PIN_CLOCK) || (aw_addr_reg == `ADDR_RELOCATION) ||
             (aw_addr_reg == `ADDR_IRQ_SOURCE);
    rd_hit = 1'b1;
    case (s_axi_araddr)
      `ADDR_PIN_CLOCK: rd_byte = pin_clock_reg;
      `ADDR_RELOCATION: rd_byte = relocation_reg;
      `ADDR_IRQ_SOURCE: rd_byte = irq_source_reg;
      default: begin
        rd_byte = 8'h00;
        rd_hit = 1'b0;
      end
    endcase
  end

  always @(posedge sys_clk) begin
    if (!rstn) begin
      pin_clock_reg <= `RST_PIN_CLOCK;
      relocation_reg <= `RST_RELOCATION;
      irq_source_reg <= `RST_IRQ_SOURCE;
      aw_held_reg <= 1'b0;
      w_held_reg <= 1'b0;
      aw_addr_reg <= 12'h000;
      w_data_reg <= 8'h00;
      w_strb_reg <= 1'b0;
      s_axi_awready <= 1'b0;
      s_axi_wready <= 1'b0;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= `RESP_OKAY;
      s_axi_arready <= 1'b0;
      s_axi_rvalid <= 1'b0;
      s_axi_rresp <= `RESP_OKAY;
      s_axi_rdata <= 32'h0000_0000;
    end else begin
      // one-cycle ready pulses; each channel is held until the write completes
      s_axi_awready <= !aw_held_reg && !s_axi_awready && s_axi_awvalid;
      s_axi_wready <= !w_held_reg && !s_axi_wready && s_axi_wvalid;
      if (s_axi_awready && s_axi_awvalid) begin
        aw_held_reg <= 1'b1;
        aw_addr_reg <= s_axi_awaddr;
      end
      if (s_axi_wready && s_axi_wvalid) begin
        w_held_reg <= 1'b1;
        w_data_reg <= s_axi_wdata[7:0];
        w_strb_reg <= s_axi_wstrb[0];
      end
      if (wr_fire) begin
        aw_held_reg <= 1'b0;
        w_held_reg <= 1'b0;
        s_axi_bvalid <= 1'b1;
        s_axi_bresp <= wr_hit ? `RESP_OKAY : `RESP_SLVERR;
        if (w_strb_reg && aw_addr_reg == `ADDR_PIN_CLOCK)
          pin_clock_reg <= w_data_reg;
        if (w_strb_reg && aw_addr_reg == `ADDR_RELOCATION)
          relocation_reg <= w_data_reg;
        if (w_strb_reg && aw_addr_reg == `ADDR_IRQ_SOURCE)
          irq_source_reg <= w_data_reg;
      end else if (s_axi_bvalid && s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
      end
      s_axi_arready <= !s_axi_arready && !s_axi_rvalid && s_axi_arvalid;
      if (s_axi_arready && s_axi_arvalid) begin
        s_axi_rvalid <= 1'b1;
        s_axi_rdata <= {24'h00_0000, rd_byte};
        s_axi_rresp <= rd_hit ? `RESP_OKAY : `RESP_SLVERR;
      end else if (s_axi_rvalid && s_axi_rready) begin
        s_axi_rvalid <= 1'b0;
      end
    end
  end

  // pin synchroniser, divider and flopped outputs
  always @(posedge sys_clk) begin
    if (!rstn) begin
      pin_meta_reg <= {NPIN{1'b0}};
      pin_sync_reg <= {NPIN{1'b0}};
      clk_div_reg <= 3'h0;
      pin_out <= {NPIN{1'b0}};
      pin_oe <= {NPIN{1'b0}};
      gpio_in <= {NPIN{1'b0}};
      p60_fast_drive <= 1'b0;
      spi_in <= 4'h0;
      uart_first_rx <= 1'b1;
      uart_second_rx <= 1'b1;
      timer_two_count_in <= 1'b0;
      timer_two_ext_trigger <= 1'b0;
      timer_three_count_in <= 1'b0;
      timer_three_ext_trigger <= 1'b0;
      pca_channel_pin <= 6'h00;
      pca_ext_clock_in <= 1'b0;
      keypad_irq_inputs <= 8'h00;
      ext_irq_two_in <= 1'b1;
      ext_irq_three_in <= 1'b1;
    end else begin
      pin_meta_reg <= pin_in;
      pin_sync_reg <= pin_meta_reg;
      clk_div_reg <= clk_div_reg + 3'h1;
      pin_out <= po_next;
      pin_oe <= pe_next;
      gpio_in <= pin_sync_reg;
      p60_fast_drive <= pin_clock_reg[`F_P60_FAST]; // R7
      spi_in <= spi_in_next;
      uart_first_rx <= uart1_rx_next;
      uart_second_rx <= uart2_rx_next;
      timer_two_count_in <= t2_in_next;
      timer_two_ext_trigger <= t2_ex_next;
      timer_three_count_in <= t3_in_next;
      timer_three_ext_trigger <= t3_ex_next;
      pca_channel_pin <= cex_next;
      pca_ext_clock_in <= eci_next;
      keypad_irq_inputs <= kbd_next;
      ext_irq_two_in <= irq2_next;
      ext_irq_three_in <= irq3_next;
    end
  end

endmodule

// ===== sim/pin_redirect_sva.sv
// concurrent checks on the pin redirect block ports
module pin_redirect_sva #(
  parameter NPIN = 56
) (
  // clock, reset and register bus
  input wire sys_clk,
  input wire rstn,
  input wire s_axi_awready,
  input wire s_axi_bvalid,
  input wire s_axi_bready,
  input wire [1:0] s_axi_bresp,
  input wire s_axi_rvalid,
  input wire s_axi_rready,
  input wire [31:0] s_axi_rdata,
  // pads and clock system
  input wire [NPIN-1:0] pin_in,
  input wire [NPIN-1:0] pin_oe,
  input wire [NPIN-1:0] gpio_in,
  input wire [1:0] clk_source,
  input wire p60_fast_drive
);
  timeunit 1ns;
  timeprecision 1ps;
  reg [2:0] up_reg;
  default clocking @(posedge sys_clk); endclocking
  default disable iff (!rstn);
  // gpio_in only compared once the sync chain holds post-reset samples
  always @(posedge sys_clk)
    if (!rstn) up_reg <= 3'h0;
    else if (up_reg != 3'h4) up_reg <= up_reg + 3'h1;
  resp_hold_a: assert property (s_axi_bvalid && !s_axi_bready |=>
    s_axi_bvalid && $stable(s_axi_bresp)) else $error("write response not held");
  data_hold_a: assert property (s_axi_rvalid && !s_axi_rready |=>
    s_axi_rvalid && $stable(s_axi_rdata)) else $error("read data not held");
  upper_zero_a: assert property (s_axi_rvalid |-> s_axi_rdata[31:8] == 24'h00_0000)
    else $error("upper read bits set");
  aw_pulse_a: assert property (s_axi_awready |=> !s_axi_awready)
    else $error("awready longer than one cycle");
  pin_sync_a: assert property (up_reg == 3'h4 |-> gpio_in == $past(pin_in, 3))
    else $error("gpio input latency wrong");
  ext_clock_a: assert property (clk_source != 2'h0 && $stable(clk_source) |-> !pin_oe[48])
    else $error("p6.0 driven outside internal rc mode");
  xtal_pins_a: assert property (clk_source == 2'h1 && $stable(clk_source) |->
    pin_oe[49:48] == 2'h0) else $error("crystal pins driven");
  fast_write_a: assert property ($changed(p60_fast_drive) |->
    s_axi_bvalid || $past(s_axi_bvalid)) else $error("fast drive changed without write");
  cover property (s_axi_bvalid && s_axi_bready && s_axi_bresp == 2'h2);
  cover property (s_axi_rvalid && s_axi_rready);
  cover property (pin_oe[48] && $changed(pin_in[48]));
endmodule

bind alternate_function_pin_redirect pin_redirect_sva #(.NPIN(NPIN)) pin_redirect_sva_inst (.*);

// ===== sim/pin_pad_model.sv
// pad model: driven pads read back the block, released pads show the board pattern
module pin_pad_model (
  // block side
  input wire logic [55:0] pin_out,
  input wire logic [55:0] pin_oe,
  // board side
  input wire logic [55:0] ext,
  output logic [55:0] pin_in
);
  timeunit 1ns;
  timeprecision 1ps;
  // no pulls here, so a released pad never keeps its last driven level
  assign pin_in = (pin_oe & pin_out) | (~pin_oe & ext);
endmodule

// ===== sim/alternate_function_pin_redirect_tb.sv
// random and corner stimulus bench for the pin redirect block
`include "pin_redirect_consts.vh"
module alternate_function_pin_redirect_tb;
  timeunit 1ns;
  timeprecision 1ps;
  logic sys_clk = 1'h0, rstn = 1'h0, s_axi_awvalid = 1'h0, s_axi_wvalid = 1'h0;
  logic s_axi_bready = 1'h0, s_axi_arvalid = 1'h0, s_axi_rready = 1'h0, last;
  logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  logic [11:0] s_axi_awaddr = '0, s_axi_araddr = '0;
  logic [31:0] s_axi_wdata = '0, s_axi_rdata;
  logic [3:0] s_axi_wstrb = 4'hf, spi_out = '0, spi_oe = 4'hb, spi_in;
  logic [1:0] s_axi_bresp, s_axi_rresp, clk_source = 2'h0;
  logic [55:0] pin_in, pin_out, pin_oe, gpio_in, ext = '0, gpio_out = '0, gpio_oe = '0;
  logic p60_fast_drive, uart_first_rx, uart_second_rx, pca_ext_clock_in;
  logic uart_first_tx = 1'h1, uart_second_tx = 1'h1, timer_two_clock_out = 1'h0;
  logic timer_three_clock_out = 1'h0, timer_two_clock_oe = 1'h1, timer_three_clock_oe = 1'h1;
  logic timer_two_count_in, timer_two_ext_trigger, timer_three_count_in, timer_three_ext_trigger;
  logic [5:0] pca_channel_out = '0, pca_channel_oe = 6'h3f, pca_channel_pin;
  logic [7:0] keypad_irq_inputs;
  logic ext_irq_two_in, ext_irq_three_in;
  logic [63:0] r;
  int n_mismatch = 0, n_compared = 0, cyc = 0, seed = 32'h7d4e, k, t, b;
  int vac[5] = '{0, 13, 11, 8, 18};
  int i2[4] = '{35, 24, 33, 12};
  int i3[4] = '{34, 10, 33, 12};
  int kp[4] = '{0, 2, 5, 6};
  alternate_function_pin_redirect alternate_function_pin_redirect_inst (.*);
  pin_pad_model pin_pad_model_inst (.pin_out(pin_out), .pin_oe(pin_oe), .ext(ext), .pin_in(pin_in));
  initial forever #4 sys_clk = ~sys_clk;
  always @(posedge sys_clk) begin
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      n_mismatch++;
      summarize();
    end
  end
  task check(input logic [31:0] got, input logic [31:0] exp);
    n_compared++;
    if (got !== exp) begin
      n_mismatch++;
      $display("mismatch at %0t: got %0h expected %0h", $time, got, exp);
    end
  endtask
  task summarize;
    $display("compared %0d mismatched %0d", n_compared, n_mismatch);
    if (n_mismatch == 0 && n_compared > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask
  task wr(input logic [11:0] a, input logic [7:0] d, input logic [1:0] er);
    s_axi_awaddr <= a;
    s_axi_wdata <= {24'h00_0000, d};
    s_axi_awvalid <= 1'h1;
    s_axi_wvalid <= 1'h1;
    s_axi_bready <= 1'h1;
    do begin
      @(posedge sys_clk);
      if (s_axi_awready) s_axi_awvalid <= 1'h0;
      if (s_axi_wready) s_axi_wvalid <= 1'h0;
    end while (!s_axi_bvalid);
    check(s_axi_bresp, er);
    s_axi_bready <= 1'h0;
    @(posedge sys_clk);
  endtask
  task rd(input logic [11:0] a, input logic [7:0] e, input logic [1:0] er);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'h1;
    s_axi_rready <= 1'h1;
    do begin
      @(posedge sys_clk);
      if (s_axi_arready) s_axi_arvalid <= 1'h0;
    end while (!s_axi_rvalid);
    check(s_axi_rdata, {24'h00_0000, e});
    check(s_axi_rresp, er);
    s_axi_rready <= 1'h0;
    @(posedge sys_clk);
  endtask
  // new pad and peripheral values, then held long enough to cross the sync chain
  task stim;
    @(posedge sys_clk);
    r = {$random(seed), $random(seed)};
    ext <= r[55:0];
    gpio_out <= ~r[63:8];
    gpio_oe <= r[59:4];
    spi_out <= r[3:0];
    {uart_first_tx, uart_second_tx, timer_two_clock_out, timer_three_clock_out} <= r[7:4];
    pca_channel_out <= r[13:8];
    pca_channel_oe <= r[19:14];
    {spi_oe, timer_two_clock_oe, timer_three_clock_oe} <= r[25:20];
    repeat (6) @(posedge sys_clk);
  endtask
  initial begin
    repeat (6) @(posedge sys_clk);
    rstn <= 1'h1;
    @(posedge sys_clk);
    rd(`ADDR_PIN_CLOCK, 8'h00, `RESP_OKAY);
    rd(`ADDR_RELOCATION, 8'h00, `RESP_OKAY);
    rd(`ADDR_IRQ_SOURCE, 8'h00, `RESP_OKAY);
    wr(12'h0290, 8'h5a, `RESP_SLVERR);
    rd(12'h0290, 8'h00, `RESP_SLVERR);
    wr(`ADDR_IRQ_SOURCE, 8'ha5, `RESP_OKAY);
    rd(`ADDR_IRQ_SOURCE, 8'ha5, `RESP_OKAY);
    // low byte strobe clear: accepted but nothing stored
    s_axi_wstrb <= 4'he;
    wr(`ADDR_IRQ_SOURCE, 8'h3c, `RESP_OKAY);
    s_axi_wstrb <= 4'hf;
    rd(`ADDR_IRQ_SOURCE, 8'ha5, `RESP_OKAY);
    wr(`ADDR_IRQ_SOURCE, 8'h00, `RESP_OKAY);
    $display("register test done");
    for (k = 0; k < 5; k++) begin
      wr(`ADDR_RELOCATION, k ? 8'h40 >> k : 8'h00, `RESP_OKAY);
      stim();
      b = k == 1 ? 44 : 12;
      check(pin_out[b + 1], spi_out[1]);
      check(pin_out[b + 3], spi_out[3]);
      check(spi_in[2], pin_in[b + 2]);
      check(pin_oe[b +: 4], spi_oe);
      b = k == 2 ? 42 : 10;
      check(uart_second_rx, pin_in[b]);
      check(pin_out[b + 1], uart_second_tx);
      check(pin_oe[b +: 2], 2'h2);
      b = k == 3 ? 40 : 8;
      check(pin_out[b], timer_two_clock_out);
      check(timer_two_ext_trigger, pin_in[b + 1]);
      check(timer_two_count_in, pin_in[b]);
      check(pin_oe[b +: 2], {1'h0, timer_two_clock_oe});
      b = k == 4 ? 49 : 17;
      check(pca_ext_clock_in, pin_in[b]);
      check(pin_out[b + 1 +: 6], pca_channel_out);
      check(pca_channel_pin, pin_in[b + 1 +: 6]);
      check(pin_oe[b +: 7], {pca_channel_oe, 1'h0});
      if (k) check(pin_out[vac[k]], gpio_out[vac[k]]);
    end
    $display("relocation test done");
    for (k = 0; k < 4; k++) begin
      wr(`ADDR_PIN_CLOCK, 8'(k * 4), `RESP_OKAY);
      stim();
      case (k)
        0: check(pin_out[37], gpio_out[37]);
        1: check(pin_out[37], uart_first_tx);
        2: check(ext_irq_three_in, pin_in[37]);
        3: check(pin_out[37], timer_three_clock_out);
      endcase
      if (k) check(k == 1 ? uart_first_rx : k == 2 ? ext_irq_two_in : timer_three_ext_trigger,
        pin_in[36]);
      else check(uart_first_rx, pin_in[24]);
      check(timer_three_count_in, pin_in[k == 3 ? 37 : 1]);
    end
    for (k = 0; k < 4; k++) begin
      wr(`ADDR_IRQ_SOURCE, 8'(k * 8'h50), `RESP_OKAY);
      stim();
      check(ext_irq_two_in, pin_in[i2[k]]);
      check(ext_irq_three_in, pin_in[i3[k]]);
    end
    $display("port 4 and irq source test done");
    for (k = 0; k < 4; k++) begin
      wr(`ADDR_PIN_CLOCK, 8'(k * 64), `RESP_OKAY);
      repeat (4) @(posedge sys_clk);
      last = pin_out[48];
      t = 0;
      for (b = 0; b < 32; b++) begin
        @(posedge sys_clk);
        t += pin_out[48] !== last;
        last = pin_out[48];
      end
      check(t, k ? 64 >> k : 0);
      check(pin_oe[48], k ? 1'h1 : gpio_oe[48]);
    end
    clk_source <= 2'h1;
    repeat (4) @(posedge sys_clk);
    check(pin_oe[49:48], 2'h0);
    clk_source <= 2'h2;
    wr(`ADDR_PIN_CLOCK, 8'he0, `RESP_OKAY);
    check(p60_fast_drive, 1'h1);
    check(pin_oe[48], 1'h0);
    $display("clock output test done");
    for (k = 0; k < 4; k++) begin
      wr(`ADDR_RELOCATION, 8'(k * 64), `RESP_OKAY);
      stim();
      check(keypad_irq_inputs, pin_in[kp[k] * 8 +: 8]);
    end
    $display("keypad test done");
    summarize();
  end
endmodule
